// ---- rtl/serial_xmit_recv_control.sv ----
// transmit and receive control of a sync/async serial transceiver
// assumes an apb master on clk; bit clocks, rxd, cts and sync pin are async
//
// What this block does
// - transmit-ready pin gated by transmit enable
// - transmit-ready clears at data write setup
// - status transmit-ready bit ignores transmit enable
// - idle pin high when empty or disabled
// - idle pin stays high while sync fillers shift
// - transmit rate is clock divided by 1/16/64
// - transmit data shifts on bit clock fall
// - async receiver waits for line high once
// - start bit rechecked low at its centre in x16/x64 (x1 goes straight to data bits)
// - missing stop bit sets framing error
// - receive data sampled on bit clock rise
// - receive-available needs enabled receiver, full character
// - unread character overwritten, overrun set
// - read during transfer still sets overrun
// - receive rate is clock divided by 1/16/64
// - sync pin resets to output driven low
// - internal sync found sets pin, status read clears
// - external sync level starts assembly next rise
// - break after two low frames, clears high
// - send only with enable and clear-to-send, except sync fillers after the first character
// - data read clears receive-available
// - first control word is mode, then commands
`timescale 1ns/10ps
`include "serial_xr_consts.svh"

module serial_xmit_recv_control
  import serial_xr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        xmit_bit_clock,
  input  wire logic        recv_bit_clock,
  input  wire logic        rxd,
  input  wire logic        cts_n,
  input  wire logic        sync_found_in,
  output logic             sync_found_out,
  output logic             sync_found_oe,
  output logic             txd,
  output logic             xmit_can_accept,
  output logic             xmit_idle_pin,
  output logic             recv_char_available,
  output logic             line_break_flag
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [6:0] factor_of(input logic [1:0] f);
    case (f)
      `SXR_FACT_X16: factor_of = 7'h10;
      `SXR_FACT_X64: factor_of = 7'h40;
      default:       factor_of = 7'h01;
    endcase
  endfunction

  function automatic logic [7:0] len_mask(input logic [3:0] n);
    len_mask = 8'(9'h0ff >> (4'h8 - n));
  endfunction

  // ----------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------
  logic [1:0] txc_s_ff, rxc_s_ff, rxd_s_ff, cts_s_ff, syn_s_ff;
  logic       txc_d_ff, rxc_d_ff;

  // first stage feeds only the second; edges look at the second and a delay
  always_ff @(posedge clk)
  begin
    txc_s_ff <= {txc_s_ff[0], xmit_bit_clock};
    rxc_s_ff <= {rxc_s_ff[0], recv_bit_clock};
    rxd_s_ff <= {rxd_s_ff[0], rxd};
    cts_s_ff <= {cts_s_ff[0], cts_n};
    syn_s_ff <= {syn_s_ff[0], sync_found_in};
    txc_d_ff <= txc_s_ff[1];
    rxc_d_ff <= rxc_s_ff[1];
  end

  logic tx_fall, rx_rise, line, cts_ok;
  assign tx_fall = txc_d_ff & ~txc_s_ff[1];
  assign rx_rise = ~rxc_d_ff & rxc_s_ff[1];
  assign line    = rxd_s_ff[1];
  assign cts_ok  = ~cts_s_ff[1];

  // ----------------------------------------
  // control words
  // ----------------------------------------
  mode_t      mode_ff;
  cmd_t       cmd_ff;
  logic       mode_done_ff;
  logic [7:0] sync1_ff, sync2_ff;
  logic       sync_sel_ff;

  logic acc, wr, rd, a_data, a_ctrl, a_stat, a_sync, mapped;
  assign a_data = paddr == `SXR_OFS_DATA;
  assign a_ctrl = paddr == `SXR_OFS_CTRL;
  assign a_stat = paddr == `SXR_OFS_STATUS;
  assign a_sync = paddr == `SXR_OFS_SYNC;
  assign mapped = a_data | a_ctrl | a_stat | a_sync;
  assign acc    = psel & penable & pready;
  assign wr     = acc & pwrite & mapped;
  assign rd     = acc & ~pwrite & mapped;

  logic ireset, is_async, hunt_cmd;
  assign ireset   = wr & a_ctrl & mode_done_ff & pwdata[6];
  assign is_async = mode_ff.factor != `SXR_FACT_SYNC;
  assign hunt_cmd = wr & a_ctrl & mode_done_ff & pwdata[7] & ~is_async;

  logic [3:0] len;
  logic [6:0] fact;
  assign len  = 4'h5 + {2'h0, mode_ff.len_code};
  assign fact = factor_of(mode_ff.factor);

  // first control word is the mode, later ones are commands
  always_ff @(posedge clk)
  begin
    if (srst || ireset)
    begin
      mode_ff      <= mode_t'(`SXR_RST_MODE);
      cmd_ff       <= cmd_t'(`SXR_RST_CMD);
      mode_done_ff <= 1'b0;
    end
    else if (wr && a_ctrl)
    begin
      if (!mode_done_ff)
      begin
        mode_ff      <= mode_t'(pwdata[7:0]);
        mode_done_ff <= 1'b1;
      end
      else
        cmd_ff <= cmd_t'(pwdata[7:0]);
    end
  end

  // sync characters alternate first/second on each write
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sync1_ff    <= `SXR_RST_SYNC;
      sync2_ff    <= `SXR_RST_SYNC;
      sync_sel_ff <= 1'b0;
    end
    else if (wr && a_sync)
    begin
      if (sync_sel_ff)
        sync2_ff <= pwdata[7:0];
      else
        sync1_ff <= pwdata[7:0];
      sync_sel_ff <= ~sync_sel_ff;
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  tx_state_t  tx_st_ff;
  logic [7:0] hold_ff;
  logic       hold_full_ff, filler_ff, tx_started_ff;
  logic [11:0] tx_sh_ff;
  logic [3:0]  tx_left_ff;
  logic [6:0]  tx_div_ff;
  logic        tx_tick;

  assign tx_tick = tx_fall && (tx_div_ff == fact - 7'h01);

  // divider of falling edges into bit slots
  always_ff @(posedge clk)
  begin
    if (srst || ireset || tx_tick)
      tx_div_ff <= 7'h00;
    else if (tx_fall)
      tx_div_ff <= tx_div_ff + 7'h01;
  end

  // frame builder: start, data lsb first, parity, stop bits
  logic [7:0]  tx_word;
  logic        tx_par;
  logic [11:0] tx_frame;
  logic [3:0]  tx_len;
  logic [7:0]  tx_src;
  always_comb
  begin
    tx_src   = hold_full_ff ? hold_ff : sync1_ff;
    tx_word  = tx_src & len_mask(len);
    tx_par   = mode_ff.even ? ^tx_word : ~^tx_word;
    tx_frame = {4'h0, tx_word} | (~12'h000 << (len + {3'h0, mode_ff.par_en}));
    if (mode_ff.par_en)
      tx_frame[len] = tx_par;
    tx_len = len + {3'h0, mode_ff.par_en};
    if (is_async)
    begin
      tx_frame = {tx_frame[10:0], 1'b0};
      tx_len   = tx_len + 4'h2 + {3'h0, mode_ff.sync_double};
    end
  end

  logic tx_go, tx_fill;
  assign tx_go   = hold_full_ff && cmd_ff.tx_en && cts_ok;
  assign tx_fill = !is_async && tx_started_ff && !hold_full_ff;

  // shifter; a disable lets the current character finish
  always_ff @(posedge clk)
  begin
    if (srst || ireset)
    begin
      tx_st_ff      <= T_IDLE;
      txd           <= 1'b1;
      tx_sh_ff      <= 12'hfff;
      tx_left_ff    <= 4'h0;
      filler_ff     <= 1'b0;
      tx_started_ff <= 1'b0;
    end
    else if (tx_tick)
    begin
      if (tx_st_ff == T_RUN && tx_left_ff != 4'h0)
      begin
        txd        <= tx_sh_ff[0] & ~cmd_ff.send_break;
        tx_sh_ff   <= {1'b1, tx_sh_ff[11:1]};
        tx_left_ff <= tx_left_ff - 4'h1;
      end
      else if (tx_go || tx_fill)
      begin
        tx_st_ff      <= T_RUN;
        txd           <= tx_frame[0] & ~cmd_ff.send_break;
        tx_sh_ff      <= {1'b1, tx_frame[11:1]};
        tx_left_ff    <= tx_len - 4'h1;
        filler_ff     <= !tx_go;
        tx_started_ff <= 1'b1;
      end
      else
      begin
        tx_st_ff  <= T_IDLE;
        txd       <= ~cmd_ff.send_break;     // marking unless break
        filler_ff <= 1'b0;
      end
    end
  end

  logic tx_take;
  assign tx_take = tx_tick && tx_go && !(tx_st_ff == T_RUN && tx_left_ff != 4'h0);

  // holding register; ready drops at the setup phase of a data write
  logic wr_setup;
  assign wr_setup = psel && !penable && pwrite && a_data;
  logic can_accept_ff;
  always_ff @(posedge clk)
  begin
    if (srst || ireset)
    begin
      hold_ff       <= 8'h00;
      hold_full_ff  <= 1'b0;
      can_accept_ff <= 1'b0;
    end
    else
    begin
      if (wr && a_data)
      begin
        hold_ff      <= pwdata[7:0];
        hold_full_ff <= 1'b1;
      end
      else if (tx_take)
        hold_full_ff <= 1'b0;
      // held low over the whole data write so the pin cannot bounce before the load
      if (psel && pwrite && a_data)
        can_accept_ff <= 1'b0;
      else
        can_accept_ff <= mode_done_ff && !hold_full_ff;
    end
  end

  // pins: ready masked by enable, idle forced high while disabled
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      xmit_can_accept <= 1'b0;
      xmit_idle_pin   <= 1'b1;
    end
    else
    begin
      xmit_can_accept <= can_accept_ff && cmd_ff.tx_en && !wr_setup;
      xmit_idle_pin   <= !cmd_ff.tx_en ||
                         (!hold_full_ff && (tx_st_ff == T_IDLE || filler_ff));
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  rx_state_t  rx_st_ff;
  logic       armed_ff, line_d_ff, rx_par_ff;
  logic [7:0] rx_sh_ff, rx_data_ff;
  logic [6:0] rx_cnt_ff;
  logic [3:0] rx_idx_ff;
  logic       avail_ff, par_err_ff, ovr_ff, frm_err_ff, found_ff, brk_ff;

  logic [7:0] rx_new, rx_win;
  logic [6:0] rx_half;
  logic       rx_slot, rx_done, rx_bad_par, rx_bad_stop, found_set;
  logic [3:0] rx_last;
  always_comb
  begin
    rx_new      = {line, rx_sh_ff[7:1]};
    rx_win      = 8'(rx_new >> (4'h8 - len));
    rx_half     = (fact >> 1) - 7'h01;
    rx_slot     = rx_rise && (rx_cnt_ff == fact - 7'h01);
    rx_last     = len + {3'h0, mode_ff.par_en} - {3'h0, ~is_async};
    rx_done     = rx_st_ff == R_BITS && rx_slot && rx_idx_ff == rx_last;
    rx_bad_par  = mode_ff.par_en &&
                  ((rx_par_ff ^ (rx_idx_ff == len ? line : 1'b0)) == mode_ff.even);
    rx_bad_stop = is_async && !line;
    found_set   = rx_rise && !mode_ff.sync_ext &&
                  ((rx_st_ff == R_HUNT && rx_win == sync1_ff && !mode_ff.sync_double) ||
                   (rx_st_ff == R_SYNC2 && rx_idx_ff == len - 4'h1 &&
                    rx_win == sync2_ff));
  end

  // character assembly state machine
  always_ff @(posedge clk)
  begin
    if (srst || ireset)
    begin
      rx_st_ff  <= R_IDLE;
      armed_ff  <= 1'b0;
      line_d_ff <= 1'b1;
      rx_sh_ff  <= 8'hff;
      rx_cnt_ff <= 7'h00;
      rx_idx_ff <= 4'h0;
      rx_par_ff <= 1'b0;
    end
    else if (hunt_cmd)
    begin
      rx_st_ff <= R_HUNT;
      rx_sh_ff <= 8'hff;                     // hunt starts from all ones
    end
    else if (rx_rise && mode_done_ff)
    begin
      line_d_ff <= line;
      rx_cnt_ff <= rx_slot ? 7'h00 : rx_cnt_ff + 7'h01;
      case (rx_st_ff)
        R_IDLE:
        begin
          if (!is_async)
            rx_st_ff <= R_IDLE;
          else if (!armed_ff)
            armed_ff <= line;
          else if (line_d_ff && !line)
          begin
            rx_cnt_ff <= 7'h00;
            rx_idx_ff <= 4'h0;
            rx_par_ff <= 1'b0;
            rx_st_ff  <= (fact == 7'h01) ? R_BITS : R_START;
          end
        end
        R_START:
        begin
          if (rx_cnt_ff == rx_half)
          begin
            rx_cnt_ff <= 7'h00;
            rx_st_ff  <= line ? R_IDLE : R_BITS;
          end
        end
        R_HUNT:
        begin
          rx_sh_ff  <= rx_new;
          rx_idx_ff <= 4'h0;
          rx_par_ff <= 1'b0;
          rx_cnt_ff <= 7'h00;
          if (mode_ff.sync_ext ? syn_s_ff[1] : rx_win == sync1_ff)
            rx_st_ff <= mode_ff.sync_double && !mode_ff.sync_ext ? R_SYNC2 : R_BITS;
        end
        R_SYNC2:
        begin
          rx_sh_ff  <= rx_new;
          rx_idx_ff <= rx_idx_ff + 4'h1;
          if (rx_idx_ff == len - 4'h1)
          begin
            rx_idx_ff <= 4'h0;
            rx_st_ff  <= rx_win == sync2_ff ? R_BITS : R_HUNT;
          end
        end
        R_BITS:
        begin
          if (rx_slot)
          begin
            rx_idx_ff <= rx_idx_ff + 4'h1;
            if (rx_idx_ff < len)
              rx_sh_ff <= rx_new;
            if (rx_idx_ff <= len)
              rx_par_ff <= rx_par_ff ^ line;   // parity bit folds in too
            if (rx_done)
            begin
              rx_idx_ff <= 4'h0;
              rx_par_ff <= 1'b0;
              rx_st_ff  <= is_async ? R_IDLE : R_BITS;
            end
          end
        end
        default: rx_st_ff <= R_IDLE;
      endcase
    end
  end

  // output register and error flags; a set beats a clear in the same cycle, except receiver disable clearing available
  logic data_rd, stat_rd, err_clr;
  assign data_rd = rd && a_data;
  assign stat_rd = rd && a_stat;
  assign err_clr = wr && a_ctrl && mode_done_ff && pwdata[4];
  always_ff @(posedge clk)
  begin
    if (srst || ireset)
    begin
      rx_data_ff <= 8'h00;
      avail_ff   <= 1'b0;
      ovr_ff     <= 1'b0;
      par_err_ff <= 1'b0;
      frm_err_ff <= 1'b0;
    end
    else
    begin
      if (rx_done)   // unused bits read zero; sync without parity ends on a data bit still in flight
        rx_data_ff <= (rx_idx_ff < len) ? rx_win : 8'(rx_sh_ff >> (4'h8 - len));
      if (!cmd_ff.rx_en)
        avail_ff <= 1'b0;
      else if (rx_done)
        avail_ff <= 1'b1;
      else if (data_rd)
        avail_ff <= 1'b0;
      if (rx_done && cmd_ff.rx_en && (avail_ff || data_rd))
        ovr_ff <= 1'b1;
      else if (err_clr)
        ovr_ff <= 1'b0;
      if (rx_done && rx_bad_par)
        par_err_ff <= 1'b1;
      else if (err_clr)
        par_err_ff <= 1'b0;
      if (rx_done && rx_bad_stop)
        frm_err_ff <= 1'b1;
      else if (err_clr)
        frm_err_ff <= 1'b0;
    end
  end

  // break counts receive clock rises while the line stays low
  logic [11:0] brk_cnt_ff;
  logic [11:0] brk_thr;
  assign brk_thr = 12'({5'h0, len + {3'h0, mode_ff.par_en} + 4'h2} * 12'(fact) * 12'h002);
  always_ff @(posedge clk)
  begin
    if (srst || ireset || line || !is_async)
    begin
      brk_cnt_ff <= 12'h000;
      brk_ff     <= 1'b0;
    end
    else if (rx_rise)
    begin
      if (brk_cnt_ff < brk_thr)
        brk_cnt_ff <= brk_cnt_ff + 12'h001;
      else
        brk_ff <= 1'b1;
    end
  end

  // sync found: internal detection or external sync level in hunt; any status read clears
  always_ff @(posedge clk)
  begin
    if (srst || ireset)
      found_ff <= 1'b0;
    else if (found_set || (mode_ff.sync_ext && rx_st_ff == R_HUNT && rx_rise && syn_s_ff[1]))
      found_ff <= 1'b1;
    else if (stat_rd)
      found_ff <= 1'b0;
  end

  // ----------------------------------------
  // pins of the receive side
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      recv_char_available <= 1'b0;
      line_break_flag     <= 1'b0;
      sync_found_out      <= 1'b0;
      sync_found_oe       <= 1'b1;
    end
    else
    begin
      recv_char_available <= avail_ff && !data_rd;
      line_break_flag     <= brk_ff;
      sync_found_out      <= is_async ? brk_ff : found_ff;
      sync_found_oe       <= is_async || !mode_ff.sync_ext;
    end
  end

  // ----------------------------------------
  // apb slave: one wait state, answer registered
  // ----------------------------------------
  logic [7:0] status;
  always_comb
  begin
    status                     = 8'h00;
    status[`SXR_ST_CAN_ACCEPT] = can_accept_ff;
    status[`SXR_ST_RX_AVAIL]   = avail_ff;
    status[`SXR_ST_TX_IDLE]    = xmit_idle_pin;
    status[`SXR_ST_PAR_ERR]    = par_err_ff;
    status[`SXR_ST_OVERRUN]    = ovr_ff;
    status[`SXR_ST_FRAME_ERR]  = frm_err_ff;
    status[`SXR_ST_SYNC_FOUND] = found_ff;
    status[`SXR_ST_BREAK]      = brk_ff;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite)
        prdata <= a_data ? {24'h0, rx_data_ff} :
                  a_stat ? {24'h0, status} :
                  a_sync ? {24'h0, sync1_ff} : 32'h0000_0000;
    end
  end

endmodule

// ---- rtl/serial_xr_consts.svh ----
// register offsets, field positions and reset values of the serial transceiver
// assumes a 32-bit apb slave with one aligned word per register
`ifndef SERIAL_XR_CONSTS_SVH
`define SERIAL_XR_CONSTS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SXR_OFS_DATA   8'h00
`define SXR_OFS_CTRL   8'h04
`define SXR_OFS_STATUS 8'h08
`define SXR_OFS_SYNC   8'h0c
// ----------------------------------------
// status bit positions
// ----------------------------------------
`define SXR_ST_CAN_ACCEPT 0
`define SXR_ST_RX_AVAIL   1
`define SXR_ST_TX_IDLE    2
`define SXR_ST_PAR_ERR    3
`define SXR_ST_OVERRUN    4
`define SXR_ST_FRAME_ERR  5
`define SXR_ST_SYNC_FOUND 6
`define SXR_ST_BREAK      7
// ----------------------------------------
// factor codes and reset values
// ----------------------------------------
`define SXR_FACT_SYNC  2'h0
`define SXR_FACT_X1    2'h1
`define SXR_FACT_X16   2'h2
`define SXR_FACT_X64   2'h3
`define SXR_RST_MODE   8'h00
`define SXR_RST_CMD    8'h00
`define SXR_RST_SYNC   8'h00
`endif

// ---- rtl/serial_xr_pkg.sv ----
// types used only by the serial transceiver control, not by its bench
// assumes nothing of its surroundings
package serial_xr_pkg;
  // mode word: [7] second stop bit (async) or [7:6] {double, ext} sync, [5] even,
  // [4] parity on, [3:2] length-5, [1:0] factor
  typedef struct packed {
    logic       sync_double;
    logic       sync_ext;
    logic       even;
    logic       par_en;
    logic [1:0] len_code;
    logic [1:0] factor;
  } mode_t;
  typedef struct packed {
    logic hunt;
    logic int_reset;
    logic rsv1;
    logic err_reset;
    logic send_break;
    logic rx_en;
    logic rsv0;
    logic tx_en;
  } cmd_t;
  typedef enum logic [1:0] {T_IDLE, T_RUN} tx_state_t;
  typedef enum logic [2:0] {R_IDLE, R_START, R_BITS, R_HUNT, R_SYNC2} rx_state_t;
endpackage

// ---- sim/serial_line_model.sv ----
// modem side of the serial line: bit clocks, receive line, transmit sampler
// assumes x1 factor and free-running bit clocks from a rate generator
`timescale 1ns/10ps
module serial_line_model (
  output logic xmit_bit_clock,
  output logic recv_bit_clock,
  output logic rxd,
  input  logic txd
);
  // -----------------------------
  // rate generator, phase unrelated to clk
  // -----------------------------
  initial
  begin
    xmit_bit_clock = 1'b0;
    recv_bit_clock = 1'b0;
    rxd = 1'b1;
  end
  always #323 xmit_bit_clock = ~xmit_bit_clock;
  always #317 recv_bit_clock = ~recv_bit_clock;

  // level for n bit times, changed on the fall so the rise sees it settled
  task automatic line(input logic v, input int n);
    repeat (n)
    begin
      @(negedge recv_bit_clock);
      rxd = v;
    end
  endtask

  // start, data lsb first, parity, stop, then one idle bit
  task automatic send(input logic [10:0] f);
    for (int i = 0; i < 11; i++)
      line(f[i], 1);
    line(1'b1, 1);
  endtask

  // sample mid-bit on the rise, half a bit after the shifting fall
  task automatic take(output logic [10:0] f);
    do @(posedge xmit_bit_clock); while (txd !== 1'b0);
    f[0] = txd;
    for (int i = 1; i < 11; i++)
    begin
      @(posedge xmit_bit_clock);
      f[i] = txd;
    end
  endtask
endmodule

// ---- sim/serial_xmit_recv_control_checker.sv ----
// port-level checks of the serial transceiver control
// assumes a bind to the design top; one clock domain on clk
`timescale 1ns/10ps
`include "serial_xr_consts.svh"
module serial_xmit_recv_control_checker (
  input logic        clk,
  input logic        srst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        xmit_bit_clock,
  input logic        recv_bit_clock,
  input logic        rxd,
  input logic        cts_n,
  input logic        sync_found_in,
  input logic        sync_found_out,
  input logic        sync_found_oe,
  input logic        txd,
  input logic        xmit_can_accept,
  input logic        xmit_idle_pin,
  input logic        recv_char_available,
  input logic        line_break_flag
);
  logic [7:0] hi_cnt_ff;
  // -----------------------------
  // rxd high run, saturating so the break check fires once per high run
  // -----------------------------
  always_ff @(posedge clk)
    if (srst || !rxd)
      hi_cnt_ff <= 8'h00;
    else if (hi_cnt_ff != 8'hff)
      hi_cnt_ff <= hi_cnt_ff + 8'h01;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not one wait state");
  a_unmapped_err: assert property (pready |-> pslverr == !(paddr inside {`SXR_OFS_DATA,
    `SXR_OFS_CTRL, `SXR_OFS_STATUS, `SXR_OFS_SYNC}))
    else $error("pslverr does not match address map");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_reset_sync: assert property ($fell(srst) |-> sync_found_oe && !sync_found_out)
    else $error("sync pin not output low after reset");
  a_reset_line: assert property ($fell(srst) |-> txd && xmit_idle_pin && !recv_char_available)
    else $error("line outputs wrong after reset");
  a_data_wr_drop: assert property (psel && !penable && pwrite && paddr == `SXR_OFS_DATA
    |-> ##1 (!xmit_can_accept) [*4])
    else $error("transmit ready not cleared by data write");
  a_read_clear: assert property (pready && !pwrite && paddr == `SXR_OFS_DATA
    |-> ##[1:2] !recv_char_available)
    else $error("receive available not cleared by data read");
  a_stat_ready: assert property (pready && !pwrite && paddr == `SXR_OFS_STATUS
    && xmit_can_accept && $past(xmit_can_accept) |-> prdata[`SXR_ST_CAN_ACCEPT])
    else $error("status ready bit low while pin high");
  a_break_clear: assert property (hi_cnt_ff == 8'd40 |-> !line_break_flag)
    else $error("break flag stays after line high");

  c_slverr: cover property (pready && pslverr);
  c_break: cover property ($rose(line_break_flag));
  c_rx_avail: cover property ($rose(recv_char_available));
endmodule

bind serial_xmit_recv_control serial_xmit_recv_control_checker u_chk (.*);

// ---- sim/serial_xmit_recv_control_tb.sv ----
// self-checking bench of the serial transceiver control
// assumes the line model at the far side, async x1 with even parity
`timescale 1ns/10ps
`include "serial_xr_consts.svh"
module serial_xmit_recv_control_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        cts_n = 1'b1;
  logic        sync_found_in = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, xmit_bit_clock, recv_bit_clock, rxd, txd;
  logic        sync_found_out, sync_found_oe, xmit_can_accept, xmit_idle_pin;
  logic        recv_char_available, line_break_flag;
  logic [31:0] q;
  logic [10:0] f;
  logic [7:0]  d;
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc = 0;

  always #20 clk = ~clk;
  serial_xmit_recv_control u_dut (.*);
  serial_line_model u_line (.*);

  // -----------------------------
  // reporting and bus tasks
  // -----------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  // one edge first so a release and the next setup never share a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_rx();
    for (int i = 0; i < 3000 && recv_char_available !== 1'b1; i++)
      @(posedge clk);
  endtask
  // start, data, even parity, stop; flags corrupt parity or stop
  function automatic logic [10:0] frm(input logic [7:0] b, input logic bp, input logic bs);
    return {~bs, ^b ^ bp, b, 1'b0};
  endfunction

  // watchdog: whole run is some 2500 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  // -----------------------------
  // main sequence
  // -----------------------------
  initial
  begin
    void'($urandom(72878));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chkb("txd", 1'b1, txd);
    chkb("sync oe", 1'b1, sync_found_oe);
    apb(1'b1, `SXR_OFS_CTRL, 32'h3d);
    apb(1'b1, `SXR_OFS_CTRL, 32'h04);
    repeat (4) @(posedge clk);
    chkb("ready pin", 1'b0, xmit_can_accept);
    chkb("idle pin", 1'b1, xmit_idle_pin);
    apb(1'b0, `SXR_OFS_STATUS, 32'h0);
    chkb("ready bit", 1'b1, q[`SXR_ST_CAN_ACCEPT]);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    apb(1'b1, `SXR_OFS_CTRL, 32'h05);
    repeat (4) @(posedge clk);
    chkb("ready pin", 1'b1, xmit_can_accept);
    // transmit; first char waits for clear-to-send
    for (int k = 0; k < 3; k++)
    begin
      d = 8'($urandom);
      apb(1'b1, `SXR_OFS_DATA, {24'h0, d});
      if (k == 0)
      begin
        repeat (48) @(posedge clk);
        chkb("ready drop", 1'b0, xmit_can_accept);
        chkb("idle low", 1'b0, xmit_idle_pin);
        chkb("txd held", 1'b1, txd);
        cts_n <= 1'b0;
      end
      u_line.take(f);
      chk("tx frame", {21'h0, frm(d, 1'b0, 1'b0)}, {21'h0, f});
    end
    repeat (40) @(posedge clk);
    chkb("idle back", 1'b1, xmit_idle_pin);
    // receive: clean, bad parity, missing stop
    for (int k = 0; k < 3; k++)
    begin
      d = 8'($urandom);
      u_line.send(frm(d, k == 1, k == 2));
      wait_rx();
      chkb("rx avail", 1'b1, recv_char_available);
      apb(1'b0, `SXR_OFS_STATUS, 32'h0);
      chkb("parity err", k == 1, q[`SXR_ST_PAR_ERR]);
      chkb("frame err", k == 2, q[`SXR_ST_FRAME_ERR]);
      apb(1'b0, `SXR_OFS_DATA, 32'h0);
      chk("rx data", {24'h0, d}, q);
      repeat (3) @(posedge clk);
      chkb("rx clear", 1'b0, recv_char_available);
      apb(1'b1, `SXR_OFS_CTRL, 32'h15);
    end
    // unread char overwritten by the next
    d = 8'($urandom);
    u_line.send(frm(8'h5a, 1'b0, 1'b0));
    u_line.send(frm(d, 1'b0, 1'b0));
    repeat (8) @(posedge clk);
    apb(1'b0, `SXR_OFS_STATUS, 32'h0);
    chkb("overrun", 1'b1, q[`SXR_ST_OVERRUN]);
    apb(1'b0, `SXR_OFS_DATA, 32'h0);
    chk("newest", {24'h0, d}, q);
    // receiver off holds available low
    apb(1'b1, `SXR_OFS_CTRL, 32'h11);
    u_line.send(frm(8'($urandom), 1'b0, 1'b0));
    repeat (20) @(posedge clk);
    chkb("rx held", 1'b0, recv_char_available);
    // break: 30 low bits, two frames need 22
    apb(1'b1, `SXR_OFS_CTRL, 32'h15);
    u_line.line(1'b0, 30);
    repeat (8) @(posedge clk);
    chkb("break", 1'b1, line_break_flag);
    chkb("break pin", 1'b1, sync_found_out);
    apb(1'b0, `SXR_OFS_STATUS, 32'h0);
    chkb("break bit", 1'b1, q[`SXR_ST_BREAK]);
    u_line.line(1'b1, 3);
    chkb("break clr", 1'b0, line_break_flag);
    tally_and_finish();
  end
endmodule
